// ### sbg_defines.vh
`ifndef SBG_DEFINES_VH
`define SBG_DEFINES_VH

// Register byte offsets
`define SBG_OFS_BAUD_CONTROL   8'h00
`define SBG_OFS_DIVISOR_LOW    8'h04
`define SBG_OFS_DIVISOR_HIGH   8'h08
`define SBG_OFS_TX_STATUS_CTRL 8'h0c
`define SBG_OFS_FLAGS          8'h10

// Baud control field positions
`define SBG_BC_AUTO_BAUD_OVF   7
`define SBG_BC_RX_IDLE         6
`define SBG_BC_CLK_POLARITY    4
`define SBG_BC_WIDE_GEN        3
`define SBG_BC_WAKE_UP         1
`define SBG_BC_AUTO_BAUD       0

// Transmit status and control field positions
`define SBG_TS_SYNC_MODE       4
`define SBG_TS_HIGH_SPEED      2

// Flags register field position
`define SBG_FL_RX_INT          0

// Multiplier shifts: 64, 16 and 4 clocks per divisor step
`define SBG_SHIFT_X64          3'h6
`define SBG_SHIFT_X16          3'h4
`define SBG_SHIFT_X4           3'h2

// Auto-baud measures eight bit times, an extra shift of three
`define SBG_ABD_BITS_SHIFT     4'h3
`define SBG_ABD_RISE_EDGES     3'h5

// Reset values
`define SBG_RST_BYTE           8'h00
`define SBG_RST_DIVISOR        16'h0000

`endif

// ### sbg_timer.v
`timescale 1ns/1ps
`include "sbg_defines.vh"

module sbg_timer #(
  parameter DW = 16,
  parameter PW = 6
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          rst,
  // Configuration
  input  wire          clear,
  input  wire          wide,
  input  wire [DW-1:0] divisor,
  input  wire [2:0]    shift,
  // Rate output
  output reg           tick
);

  reg  [PW-1:0] pre;
  reg  [DW-1:0] cnt;
  wire [PW:0]   pre_full;
  wire [PW-1:0] pre_top;
  wire [DW-1:0] top;

  // Prescaler top is 2^shift - 1
  assign pre_full = ({{PW{1'b0}}, 1'b1} << shift) - {{PW{1'b0}}, 1'b1};
  assign pre_top  = pre_full[PW-1:0];
  // Narrow mode only looks at the low byte
  assign top      = wide ? divisor : {{(DW-8){1'b0}}, divisor[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Free-running timer; period is (2^shift) * (top + 1) clocks
  always @(posedge mclk) begin
    if (rst || clear) begin
      pre  <= {PW{1'b0}};
      cnt  <= {DW{1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre == pre_top) begin
        pre <= {PW{1'b0}};
        // Compare with >= so a shrinking divisor never runs past the top
        if (cnt >= top) begin
          cnt  <= {DW{1'b0}};
          tick <= 1'b1;
        end else begin
          cnt <= cnt + {{(DW-1){1'b0}}, 1'b1};
        end
      end else begin
        pre <= pre + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // sbg_timer

// ### sbg_top.v
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "sbg_defines.vh"

module sbg_top #(
  parameter AW = 8,
  parameter CW = 24
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          rst,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // Serial side
  input  wire          tx_data,
  input  wire          rx_pin,
  input  wire          receive_idle_flag,
  output reg           transmit_clock_pin,
  output reg           baud_tick,
  output reg           receive_interrupt_flag
);

  localparam AB_IDLE = 3'b001;
  localparam AB_WAIT = 3'b010;
  localparam AB_MEAS = 3'b100;

  // Control registers
  reg          clock_polarity_select;
  reg          wide_generator_select;
  reg          wake_up_enable;
  reg          auto_baud_enable;
  reg          auto_baud_overflow;
  reg          sync_mode;
  reg          high_speed_select;
  reg  [7:0]   divisor_low;
  reg  [7:0]   divisor_high;
  // Receive edge and auto-baud state
  reg          rx_prev;
  reg  [2:0]   ab_state;
  reg  [2:0]   ab_rises;
  reg  [CW-1:0] ab_cnt;
  reg          ab_done;
  reg          ab_ovf;
  reg          wake_hit;
  wire         timer_tick;

  // Multiplier shift from mode bits
  function [2:0] mult_shift;
    input s;
    input w;
    input h;
    begin
      if (s)
        mult_shift = `SBG_SHIFT_X4;
      else if (!w && !h)
        mult_shift = `SBG_SHIFT_X64;
      else if (w && h)
        mult_shift = `SBG_SHIFT_X4;
      else
        mult_shift = `SBG_SHIFT_X16;
    end
  endfunction

  // Address decode, used for both write hit and slave error
  function is_mapped;
    input [AW-1:0] a;
    begin
      is_mapped = (a == `SBG_OFS_BAUD_CONTROL) || (a == `SBG_OFS_DIVISOR_LOW) ||
                  (a == `SBG_OFS_DIVISOR_HIGH) || (a == `SBG_OFS_TX_STATUS_CTRL) ||
                  (a == `SBG_OFS_FLAGS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire         acc      = psel && penable && !pready;
  wire         wr       = acc && pwrite && is_mapped(paddr);
  wire         wr_bc    = wr && (paddr == `SBG_OFS_BAUD_CONTROL);
  wire         wr_lo    = wr && (paddr == `SBG_OFS_DIVISOR_LOW);
  wire         wr_hi    = wr && (paddr == `SBG_OFS_DIVISOR_HIGH);
  wire         wr_ts    = wr && (paddr == `SBG_OFS_TX_STATUS_CTRL);
  wire         wr_fl    = wr && (paddr == `SBG_OFS_FLAGS);
  wire [2:0]   cur_sh   = mult_shift(sync_mode, wide_generator_select, high_speed_select);
  // Auto-baud writes the divisor too, so it also clears the timer
  wire         div_load = wr_lo || wr_hi || ab_done;
  wire         rx_fall  = rx_prev && !rx_pin;
  wire         rx_rise  = !rx_prev && rx_pin;

  wire [7:0] bc_value = {auto_baud_overflow, receive_idle_flag, 1'b0, clock_polarity_select,
                         wide_generator_select, 1'b0, wake_up_enable, auto_baud_enable};
  wire [7:0] ts_value = {3'h0, sync_mode, 1'b0, high_speed_select, 2'h0};

  // Auto-baud result: window count scaled down to a divisor, saturating
  wire [3:0]    ab_sh     = {1'b0, cur_sh} + `SBG_ABD_BITS_SHIFT;
  wire [CW-1:0] ab_q      = ab_cnt >> ab_sh;
  wire [15:0]   ab_q16    = (ab_q[CW-1:16] != {(CW-16){1'b0}}) ? 16'hffff : ab_q[15:0];
  wire [15:0]   ab_result = (ab_q16 == 16'h0000) ? 16'h0000 : ab_q16 - 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, data and error registered
  always @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc && !is_mapped(paddr);
      if (acc && !pwrite) begin
        case (paddr)
          `SBG_OFS_BAUD_CONTROL:   prdata <= {24'h000000, bc_value};
          `SBG_OFS_DIVISOR_LOW:    prdata <= {24'h000000, divisor_low};
          `SBG_OFS_DIVISOR_HIGH:   prdata <= {24'h000000, divisor_high};
          `SBG_OFS_TX_STATUS_CTRL: prdata <= {24'h000000, ts_value};
          `SBG_OFS_FLAGS:          prdata <= {31'h0, receive_interrupt_flag};
          default:                 prdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; hardware self-clears run before a fresh write
  always @(posedge mclk) begin
    if (rst) begin
      clock_polarity_select <= 1'b0;
      wide_generator_select <= 1'b0;
      wake_up_enable        <= 1'b0;
      auto_baud_enable      <= 1'b0;
      auto_baud_overflow    <= 1'b0;
      sync_mode             <= 1'b0;
      high_speed_select     <= 1'b0;
      divisor_low           <= `SBG_RST_BYTE;
      divisor_high          <= `SBG_RST_BYTE;
    end else begin
      if (wake_hit)
        wake_up_enable <= 1'b0;
      if (ab_done || ab_ovf)
        auto_baud_enable <= 1'b0;
      if (wr_bc) begin
        clock_polarity_select <= pwdata[`SBG_BC_CLK_POLARITY];
        wide_generator_select <= pwdata[`SBG_BC_WIDE_GEN];
        wake_up_enable        <= pwdata[`SBG_BC_WAKE_UP];
        auto_baud_enable      <= pwdata[`SBG_BC_AUTO_BAUD];
        // Overflow can only be cleared by software; a new overflow wins
        if (!pwdata[`SBG_BC_AUTO_BAUD_OVF])
          auto_baud_overflow <= 1'b0;
      end
      if (ab_ovf)
        auto_baud_overflow <= 1'b1;
      if (wr_ts) begin
        sync_mode         <= pwdata[`SBG_TS_SYNC_MODE];
        high_speed_select <= pwdata[`SBG_TS_HIGH_SPEED];
      end
      // Auto-baud result loads the pair; software writes take priority
      if (ab_done) begin
        divisor_low  <= ab_result[7:0];
        divisor_high <= ab_result[15:8];
      end
      if (wr_lo)
        divisor_low <= pwdata[7:0];
      if (wr_hi)
        divisor_high <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-baud: time from first to fifth rise, eight bit times of 0x55

  always @(posedge mclk) begin
    if (rst) begin
      ab_state <= AB_IDLE;
      ab_rises <= 3'h0;
      ab_cnt   <= {CW{1'b0}};
      ab_done  <= 1'b0;
      ab_ovf   <= 1'b0;
    end else begin
      ab_done <= 1'b0;
      ab_ovf  <= 1'b0;
      case (ab_state)
        AB_IDLE: begin
          if (auto_baud_enable && !wake_up_enable && !ab_done && !ab_ovf)
            ab_state <= AB_WAIT;
        end
        AB_WAIT: begin
          ab_cnt   <= {CW{1'b0}};
          ab_rises <= 3'h0;
          if (!auto_baud_enable)
            ab_state <= AB_IDLE;
          else if (rx_fall)
            ab_state <= AB_MEAS;
        end
        AB_MEAS: begin
          ab_cnt <= ab_cnt + {{(CW-1){1'b0}}, 1'b1};
          if (!auto_baud_enable) begin
            ab_state <= AB_IDLE;
          end else if (ab_cnt == {CW{1'b1}}) begin
            // Line stuck low or far too slow: give up and flag it
            ab_ovf   <= 1'b1;
            ab_state <= AB_IDLE;
          end else if (rx_rise) begin
            ab_rises <= ab_rises + 3'h1;
            // Start bit fall to fifth rise would be nine bits; first rise opens the window
            if (ab_rises == 3'h0)
              ab_cnt <= {CW{1'b0}};
            if (ab_rises == `SBG_ABD_RISE_EDGES - 3'h1) begin
              ab_done  <= 1'b1;
              ab_state <= AB_IDLE;
            end
          end
        end
        default: ab_state <= AB_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up detect, receive flag and pin drive
  always @(posedge mclk) begin
    if (rst) begin
      rx_prev                <= 1'b1;
      wake_hit               <= 1'b0;
      receive_interrupt_flag <= 1'b0;
      transmit_clock_pin     <= 1'b1;
      baud_tick              <= 1'b0;
    end else begin
      rx_prev   <= rx_pin;
      wake_hit  <= wake_up_enable && rx_fall && !wake_hit;
      baud_tick <= timer_tick;
      // Set wins over a software clear in the same cycle
      if (wake_hit || ab_done)
        receive_interrupt_flag <= 1'b1;
      else if (wr_fl && pwdata[`SBG_FL_RX_INT])
        receive_interrupt_flag <= 1'b0;
      // Polarity only applies to async data; sync clock edges live elsewhere
      if (!sync_mode)
        transmit_clock_pin <= tx_data ^ clock_polarity_select;
      else
        transmit_clock_pin <= tx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud timer
  sbg_timer #(
    .DW (16),
    .PW (6)
  ) u_timer (
    .mclk    (mclk),
    .rst     (rst),
    .clear   (div_load),
    .wide    (wide_generator_select),
    .divisor ({divisor_high, divisor_low}),
    .shift   (cur_sh),
    .tick    (timer_tick)
  );

endmodule // sbg_top

// ### sbg_top_sva.sv
`timescale 1ns/1ps
module sbg_chk #(
  parameter AW = 8,
  parameter CW = 24
) (
  // Clock and reset
  input wire          mclk,
  input wire          rst,
  // APB
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  // Serial side
  input wire          tx_data,
  input wire          transmit_clock_pin,
  input wire          baud_tick,
  input wire          receive_interrupt_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access did not end after one wait state");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  ////////////////////////////////////////////////////////////////////////////////
  // Serial side; shortest bit period is four clocks
  a_tick_gap: assert property (baud_tick |=> !baud_tick [*3])
    else $error("baud ticks too close");
  a_flag_clear: assert property ($fell(receive_interrupt_flag) |->
    $past(psel && penable && pwrite && paddr == 8'h10 && pwdata[0]))
    else $error("receive flag fell without a clearing write");
  a_pin_cause: assert property ($changed(transmit_clock_pin) |->
    $past(tx_data) != $past(tx_data, 2) || $past(psel && pwrite) || $past(rst, 2))
    else $error("pin changed without cause");
endmodule // sbg_chk

bind sbg_top sbg_chk #(.AW(AW), .CW(CW)) chk_u (.mclk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_data, .transmit_clock_pin, .baud_tick,
  .receive_interrupt_flag);

// ### sbg_peer.sv
`timescale 1ns/1ps
module sbg_peer (
  // Clock
  input wire mclk,
  // Line into the receiver
  output reg rx_line
);
  integer i;
  // Idle line rests high, as a pulled-up line would
  initial rx_line = 1'b1;
  // One frame, start bit low, LSB first, stop bit high
  task send_byte(input [7:0] b, input integer bit_clks);
    reg [9:0] f;
    begin
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        rx_line <= f[i];
        repeat (bit_clks) @(posedge mclk);
      end
    end
  endtask
endmodule // sbg_peer

// ### sbg_top_tb_top.sv
`timescale 1ns/1ps
module sbg_top_tb_top;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         tx_data = 1'b0;
  reg         idle = 1'b1;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        rx_pin;
  wire        pin;
  wire        baud_tick;
  wire        rflag;
  reg  [31:0] rd;
  reg         er;
  reg  [24:0] rows [0:4];
  reg  [47:0] modes [0:6];
  integer     bad_count = 0;
  integer     comparisons = 0;
  integer     k;
  integer     j;
  integer     c;
  ////////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  sbg_top dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .rx_pin(rx_pin), .receive_idle_flag(idle),
    .transmit_clock_pin(pin), .baud_tick(baud_tick), .receive_interrupt_flag(rflag));
  sbg_peer peer_u (.mclk(mclk), .rx_line(rx_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // One transfer started on an edge plus an idle cycle; waits on pready, watchdog bounds it
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
        @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task chk(input [8*6-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Clocks until the next baud tick, sampled after the edge settles
  task meas;
    begin
      c = 0;
      do begin
        @(posedge mclk);
        #1;
        c = c + 1;
      end while (baud_tick !== 1'b1 && c < 9000);
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, several times the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count = bad_count + 1;
    print_verdict;
  end
  // Main sequence
  initial begin
    rows[0] = {8'h00, 8'h3c, 8'h58, 1'b0};
    rows[1] = {8'h04, 8'ha5, 8'ha5, 1'b0};
    rows[2] = {8'h08, 8'h3c, 8'h3c, 1'b0};
    rows[3] = {8'h0c, 8'h14, 8'h14, 1'b0};
    rows[4] = {8'h20, 8'h5a, 8'h00, 1'b1};
    modes[0] = {8'h00, 8'h00, 8'h01, 8'h02, 16'd192};
    modes[1] = {8'h04, 8'h00, 8'h00, 8'h03, 16'd64};
    modes[2] = {8'h00, 8'h08, 8'h01, 8'h03, 16'd4160};
    modes[3] = {8'h04, 8'h08, 8'h00, 8'h05, 16'd24};
    modes[4] = {8'h10, 8'h00, 8'h00, 8'h07, 16'd32};
    modes[5] = {8'h14, 8'h00, 8'h00, 8'h07, 16'd32};
    modes[6] = {8'h10, 8'h08, 8'h01, 8'h00, 16'd1028};
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("pinrst", 1, pin);
    @(posedge mclk);
    apb(0, 8'h00, 0);
    chk("bcrst", 32'h40, rd);
    apb(0, 8'h04, 0);
    chk("dlrst", 0, rd);
    for (k = 0; k < 5; k = k + 1) begin
      apb(1, rows[k][24:17], {24'h0, rows[k][16:9]});
      apb(0, rows[k][24:17], 0);
      chk("regrd", {24'h0, rows[k][8:1]}, rd);
      chk("regerr", rows[k][0], er);
    end
    // Divisor low written last restarts the timer from zero
    for (k = 0; k < 7; k = k + 1) begin
      apb(1, 8'h0c, modes[k][47:40]);
      apb(1, 8'h00, modes[k][39:32]);
      apb(1, 8'h08, modes[k][31:24]);
      apb(1, 8'h04, modes[k][23:16]);
      meas;
      chk("first", modes[k][15:0] - 1, c);
      meas;
      chk("period", modes[k][15:0], c);
    end
    for (j = 0; j < 3; j = j + 1) begin
      apb(1, 8'h0c, (j == 2) ? 8'h10 : 8'h00);
      apb(1, 8'h00, (j == 1) ? 8'h00 : 8'h10);
      for (k = 0; k < 2; k = k + 1) begin
        @(posedge mclk);
        tx_data <= k[0];
        repeat (3) @(posedge mclk);
        #1;
        chk("pin", k[0] ^ (j == 0), pin);
      end
    end
    apb(1, 8'h00, 8'h02);
    peer_u.send_byte(8'hff, 4);
    chk("wake", 1, rflag);
    apb(0, 8'h00, 0);
    chk("wakebc", 32'h40, rd);
    apb(1, 8'h10, 8'h01);
    chk("fclr", 0, rflag);
    // A busy receiver must read back as not idle
    idle <= 1'b0;
    apb(0, 8'h00, 0);
    chk("busy", 0, rd[6]);
    idle <= 1'b1;
    // Receiver idle is seen before the rate is retrained
    apb(0, 8'h00, 0);
    chk("idle", 1, rd[6]);
    apb(1, 8'h0c, 8'h04);
    apb(1, 8'h00, 8'h09);
    peer_u.send_byte(8'h55, 16);
    repeat (4) @(posedge mclk);
    apb(0, 8'h04, 0);
    chk("abdiv", 3, rd);
    apb(0, 8'h00, 0);
    chk("abbc", 32'h48, rd);
    chk("abflag", 1, rflag);
    // Slow line: 64 clocks a bit at x4 gives divisor 15 only over an eight-bit window
    apb(1, 8'h00, 8'h09);
    peer_u.send_byte(8'h55, 64);
    repeat (4) @(posedge mclk);
    apb(0, 8'h04, 0);
    chk("abslow", 15, rd);
    print_verdict;
  end
endmodule // sbg_top_tb_top
